//--- hw/ccs_top.sv
// clock output, converter clock generation and overload flags
`timescale 1ns/1ns
`include "ccs_cfg.svh"

// ------------------------------------------------------------
// divider with glitch-free ratio switching; a source switch can cut the first high phase short
// ------------------------------------------------------------
module ccs_div #(
	parameter int NSRC = 2,
	parameter int SW   = 1
) (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst,
	// control
	input  wire logic [NSRC-1:0] src_lvl,
	input  wire logic [SW-1:0]   src_sel,
	input  wire logic            run,
	input  wire logic [7:0]      div_val,
	// divided clock
	output logic                 clk_out
);
	logic [SW-1:0] sel_ff;
	logic [7:0]    val_ff;
	logic [7:0]    cnt_ff;
	logic          act_ff;
	logic          src_d_ff;
	logic          out_ff;
	logic [7:0]    nxt_cnt;
	logic          nxt_out;

	// reserved selector codes read as a quiet low source
	wire        src_now = (sel_ff < NSRC) ? src_lvl[sel_ff] : 1'b0;
	wire        src_nxt = (src_sel < NSRC) ? src_lvl[src_sel] : 1'b0;
	wire        rise    = src_now & ~src_d_ff;
	wire [7:0]  last    = val_ff - 8'h01;
	wire        wrap    = rise && (cnt_ff == last);
	// new source, ratio and run state take effect at a period boundary, or at once while the divider is stopped
	wire        load    = wrap || !act_ff;
	wire [7:0]  half    = {1'b0, val_ff[7:1]};

	assign nxt_cnt = load ? 8'h00 : (rise ? cnt_ff + 8'h01 : cnt_ff);
	// a stop landing at the wrap must not start one more short high phase
	wire        nxt_act = load ? run : act_ff;
	assign nxt_out = nxt_act && ((val_ff == 8'h01) ? src_now : (nxt_cnt < half));
	assign clk_out = out_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sel_ff   <= '0;
			val_ff   <= 8'h01;
			cnt_ff   <= 8'h00;
			act_ff   <= 1'b0;
			src_d_ff <= 1'b0;
			out_ff   <= 1'b0;
		end else begin
			// a new source starts with its own history, so no false edge is counted
			src_d_ff <= load ? src_nxt : src_now;
			cnt_ff   <= nxt_cnt;
			out_ff   <= nxt_out;
			if (load) begin
				sel_ff <= src_sel;
				val_ff <= div_val;
				act_ff <= run;
			end
		end
	end
endmodule

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module ccs_top (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// gp output clock sources
	input  wire logic       pll_clk,
	input  wire logic       pasi_bclk,
	input  wire logic       sasi_bclk,
	input  wire logic       control_port_clock,
	input  wire logic       osc_clk,
	input  wire logic       dsp_clk,
	// converter clock sources and auto control
	input  wire logic       audio_clk,
	input  wire logic       audio_clk_present,
	input  wire logic       conv_auto_request,
	// overload detection
	input  wire logic       chan1_overload,
	input  wire logic       chan2_overload,
	// divided clocks
	output logic            gp_clk_out,
	output logic            conv_clk_out
);
	import ccs_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [2:0] gp_clock_source_select_ff;
	logic       gp_clock_divider_enable_ff;
	logic [6:0] gp_clock_divider_value_ff;
	logic [7:0] conv_cfg_ff;
	logic       chan1_overload_latched_ff;
	logic       chan2_overload_latched_ff;
	ccs_byte_t  rdata_ff;

	// reset images, sliced per field
	localparam ccs_byte_t GP_SRC_RST = `CCS_RST_GP_SRC;
	localparam ccs_byte_t GP_DIV_RST = `CCS_RST_GP_DIV;
	localparam ccs_byte_t OVL_RST    = `CCS_RST_OVL_FLAGS;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire hit_src  = (reg_addr == `CCS_OFS_GP_SRC);
	wire hit_div  = (reg_addr == `CCS_OFS_GP_DIV);
	wire hit_conv = (reg_addr == `CCS_OFS_CONV_CFG);
	wire hit_ovl  = (reg_addr == `CCS_OFS_OVL_FLAGS);
	wire wr_src   = reg_wr && hit_src;
	wire wr_div   = reg_wr && hit_div;
	wire wr_conv  = reg_wr && hit_conv;
	// reading the flag register is what clears the latched faults
	wire rd_ovl   = reg_rd && hit_ovl;

	// ------------------------------------------------------------
	// converter control fields
	// ------------------------------------------------------------
	wire [1:0] converter_clock_freq_mode      = conv_cfg_ff[`CCS_CONV_MODE_HI:`CCS_CONV_MODE_LO];
	wire       converter_source_auto_disable  = conv_cfg_ff[`CCS_CONV_SRC_AD];
	wire       converter_source_manual_pick   = conv_cfg_ff[`CCS_CONV_SRC_PICK];
	wire       converter_enable_auto_disable  = conv_cfg_ff[`CCS_CONV_EN_AD];
	wire       converter_divider_manual_on    = conv_cfg_ff[`CCS_CONV_EN_MAN];
	wire [1:0] converter_divider_manual_ratio = conv_cfg_ff[`CCS_CONV_RATIO_HI:0];

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	// reserved bits always read zero; unmapped offsets read zero
	wire [7:0] rd_src  = {5'h00, gp_clock_source_select_ff};
	wire [7:0] rd_div  = {gp_clock_divider_enable_ff, gp_clock_divider_value_ff};
	wire [7:0] rd_ovl_v = {chan1_overload_latched_ff, chan2_overload_latched_ff,
		chan1_overload, chan2_overload, 4'h0};
	wire [7:0] nxt_rdata = hit_src  ? rd_src :
		hit_div  ? rd_div :
		hit_conv ? conv_cfg_ff :
		hit_ovl  ? rd_ovl_v : 8'h00;

	assign reg_rdata = rdata_ff;

	// ------------------------------------------------------------
	// overload latches
	// ------------------------------------------------------------
	// a live overload in the read cycle re-sets the flag, so no event is lost
	wire nxt_ltch1 = chan1_overload | (chan1_overload_latched_ff & ~rd_ovl);
	wire nxt_ltch2 = chan2_overload | (chan2_overload_latched_ff & ~rd_ovl);

	// ------------------------------------------------------------
	// register writes, overload latches and read data
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gp_clock_source_select_ff  <= GP_SRC_RST[`CCS_GP_SEL_HI:0];
			gp_clock_divider_enable_ff <= GP_DIV_RST[`CCS_GP_EN_BIT];
			gp_clock_divider_value_ff  <= GP_DIV_RST[`CCS_GP_DIV_HI:0];
			conv_cfg_ff                <= `CCS_RST_CONV_CFG;
		end else begin
			if (wr_src) begin
				gp_clock_source_select_ff <= reg_wdata[`CCS_GP_SEL_HI:0];
			end
			if (wr_div) begin
				gp_clock_divider_enable_ff <= reg_wdata[`CCS_GP_EN_BIT];
				gp_clock_divider_value_ff  <= reg_wdata[`CCS_GP_DIV_HI:0];
			end
			if (wr_conv) begin
				conv_cfg_ff <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			chan1_overload_latched_ff <= OVL_RST[`CCS_OVL_LTCH1_BIT];
			chan2_overload_latched_ff <= OVL_RST[`CCS_OVL_LTCH2_BIT];
			rdata_ff                  <= `CCS_RST_OVL_FLAGS;
		end else begin
			chan1_overload_latched_ff <= nxt_ltch1;
			chan2_overload_latched_ff <= nxt_ltch2;
			if (reg_rd) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// general purpose clock output
	// ------------------------------------------------------------
	// source order follows the selector encoding
	wire [`CCS_GP_NSRC-1:0] gp_srcs = {dsp_clk, osc_clk, control_port_clock,
		sasi_bclk, pasi_bclk, pll_clk};
	// reserved selector codes keep the output parked low
	wire gp_sel_ok = (gp_clock_source_select_ff <= `CCS_GP_SEL_LAST);
	wire gp_run    = gp_clock_divider_enable_ff && gp_sel_ok;
	wire [7:0] gp_val = (gp_clock_divider_value_ff == 7'h00) ? `CCS_GP_DIV_ZERO_VAL :
		{1'b0, gp_clock_divider_value_ff};

	ccs_div #(
		.NSRC (`CCS_GP_NSRC),
		.SW   (3)
	) u_gp_div (
		.core_clk (core_clk),
		.rst      (rst),
		.src_lvl  (gp_srcs),
		.src_sel  (gp_clock_source_select_ff),
		.run      (gp_run),
		.div_val  (gp_val),
		.clk_out  (gp_clk_out)
	);

	// ------------------------------------------------------------
	// converter clock
	// ------------------------------------------------------------
	// auto mode falls back to the oscillator when no audio clock is detected
	wire conv_auto_src = ~audio_clk_present;
	wire conv_src = converter_source_auto_disable ?
		converter_source_manual_pick : conv_auto_src;
	wire conv_run = converter_enable_auto_disable ?
		converter_divider_manual_on : conv_auto_request;
	// auto ratio assumes a 12 MHz reference; modes 0 to 2 divide by 2, 4 and 8, the fast mode 3 passes it undivided
	wire [1:0] conv_auto_code = (converter_clock_freq_mode == `CCS_CONV_MODE_FAST) ? 2'h0 :
		converter_clock_freq_mode + 2'h1;
	// ratio follows the auto-select disable; the enable bit alone does not govern it
	wire [1:0] conv_code = converter_source_auto_disable ?
		converter_divider_manual_ratio : conv_auto_code;
	wire [7:0] conv_val  = 8'h01 << conv_code;
	wire [`CCS_CONV_NSRC-1:0] conv_srcs = {osc_clk, audio_clk};
	ccs_conv_src_t conv_src_e;
	assign conv_src_e = ccs_conv_src_t'(conv_src);

	ccs_div #(
		.NSRC (`CCS_CONV_NSRC),
		.SW   (1)
	) u_conv_div (
		.core_clk (core_clk),
		.rst      (rst),
		.src_lvl  (conv_srcs),
		.src_sel  (conv_src_e),
		.run      (conv_run),
		.div_val  (conv_val),
		.clk_out  (conv_clk_out)
	);
endmodule

//--- hw/ccs_cfg.svh
// register offsets, field positions and reset values of the clock control block
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CCS_OFS_GP_SRC      8'h46
`define CCS_OFS_GP_DIV      8'h47
`define CCS_OFS_CONV_CFG    8'h49
`define CCS_OFS_OVL_FLAGS   8'h5b

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CCS_RST_GP_SRC      8'h00
`define CCS_RST_GP_DIV      8'h01
`define CCS_RST_CONV_CFG    8'h00
`define CCS_RST_OVL_FLAGS   8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CCS_GP_SEL_HI       2
`define CCS_GP_EN_BIT       7
`define CCS_GP_DIV_HI       6
`define CCS_CONV_MODE_HI    7
`define CCS_CONV_MODE_LO    6
`define CCS_CONV_SRC_AD     5
`define CCS_CONV_SRC_PICK   4
`define CCS_CONV_EN_AD      3
`define CCS_CONV_EN_MAN     2
`define CCS_CONV_RATIO_HI   1
`define CCS_OVL_LTCH1_BIT   7
`define CCS_OVL_LTCH2_BIT   6
`define CCS_OVL_LIVE1_BIT   5
`define CCS_OVL_LIVE2_BIT   4

// ------------------------------------------------------------
// encodings and counts
// ------------------------------------------------------------
`define CCS_GP_SEL_LAST     3'h5
`define CCS_GP_DIV_ZERO_VAL 8'h80
`define CCS_CONV_MODE_FAST  2'h3
`define CCS_GP_NSRC         6
`define CCS_CONV_NSRC       2

`endif

//--- hw/ccs_pkg.sv
// types shared by the clock control block
package ccs_pkg;
	typedef enum logic [2:0] {
		CCS_GP_PLL,
		CCS_GP_PASI_BCLK,
		CCS_GP_SASI_BCLK,
		CCS_GP_CTRL_CLK,
		CCS_GP_OSC,
		CCS_GP_DSP_CLK
	} ccs_gp_src_t;

	typedef enum logic {
		CCS_CONV_AUDIO,
		CCS_CONV_OSC
	} ccs_conv_src_t;

	typedef logic [7:0] ccs_byte_t;
endpackage

//--- tb/ccs_host.sv
// host model driving the byte register port of the clock control block
`timescale 1ns/1ns
module ccs_host (
	// clock
	input  wire logic       core_clk,
	// register port
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// same byte map whichever serial control port carries it
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// released data must not look valid
		reg_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

//--- tb/ccs_top_assertions.sv
// assertions on the register port of the clock control block
`timescale 1ns/1ns
module ccs_top_chk (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// register port and overload inputs
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       chan1_overload,
	input wire logic       chan2_overload
);
	wire rd_flag = reg_rd && reg_addr == 8'h5b;
	wire rd_map  = reg_addr inside {8'h46, 8'h47, 8'h49, 8'h5b};
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	unmapped_zero_a: assert property (reg_rd && !rd_map |=> reg_rdata == 8'h00) else $error("unmapped");
	src_resv_a: assert property (reg_rd && reg_addr == 8'h46 |=> reg_rdata[7:3] == 5'h00) else $error("src resv");
	flag_resv_a: assert property (rd_flag |=> reg_rdata[3:0] == 4'h0) else $error("flag resv");
	live_one_a: assert property (rd_flag |=> reg_rdata[5] == $past(chan1_overload)) else $error("live1");
	live_two_a: assert property (rd_flag |=> reg_rdata[4] == $past(chan2_overload)) else $error("live2");
	latch_set_a: assert property (chan1_overload ##1 rd_flag |=> reg_rdata[7]) else $error("latch1");
	latch_two_a: assert property (chan2_overload ##1 rd_flag |=> reg_rdata[6]) else $error("latch2");
	latch_clear_a: assert property (rd_flag && !chan1_overload ##1 !chan1_overload ##1 rd_flag
		|=> !reg_rdata[7]) else $error("clr");
endmodule
bind ccs_top ccs_top_chk ccs_top_chk_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan1_overload(chan1_overload),
	.chan2_overload(chan2_overload));

//--- tb/tb_top.sv
// self-checking bench for the clock control block
`timescale 1ns/1ns
module tb_top;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic       reg_wr, reg_rd, gp_clk_out, conv_clk_out;
	logic       audio_clk_present = 1'b1;
	logic       conv_auto_request = 1'b0;
	logic       ovl1 = 1'b0;
	logic       ovl2 = 1'b0;
	logic [5:0] src;
	int         cnt = 0;
	int         fail_count = 0;
	int         n_tests = 0;
	int         seed = 32'hf7eb;
	int         n, v;
	wire        audio_clk = 1'((cnt / 5) % 2);
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) cnt <= cnt + 1;
	// gp source i has a half period of i+2 core cycles
	for (genvar i = 0; i < 6; i++) begin : g_src
		assign src[i] = 1'((cnt / (i + 2)) % 2);
	end
	ccs_host ccs_host_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	ccs_top ccs_top_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pll_clk(src[0]), .pasi_bclk(src[1]), .sasi_bclk(src[2]),
		.control_port_clock(src[3]), .osc_clk(src[4]), .dsp_clk(src[5]),
		.audio_clk(audio_clk), .audio_clk_present(audio_clk_present),
		.conv_auto_request(conv_auto_request), .chan1_overload(ovl1),
		.chan2_overload(ovl2), .gp_clk_out(gp_clk_out), .conv_clk_out(conv_clk_out));
	task end_sim;
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task w(input logic [7:0] a, input logic [7:0] dat);
		ccs_host_i.wr(a, dat);
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		ccs_host_i.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// cycles to the next rising edge; 3000 means none came
	task edge_wait(input bit sel);
		logic p, c;
		p = 1'b1;
		n = 0;
		while (n < 3000) begin
			@(posedge core_clk);
			#1;
			c = sel ? conv_clk_out : gp_clk_out;
			n++;
			if (c === 1'b1 && p === 1'b0)
				break;
			p = c;
		end
	endtask
	// ratio changes land at a wrap while the divider runs, so skip a few periods first
	task per_chk(input bit sel, input int e);
		repeat (4) edge_wait(sel);
		chk("period", e, n);
	endtask
	task stop_chk(input bit sel);
		repeat (2000) @(posedge core_clk);
		edge_wait(sel);
		chk("stopped", 3000, n);
	endtask
	// expected divided periods in core cycles
	function automatic int gp_per(input int s, input int dv);
		return 2 * (s + 2) * ((dv == 0) ? 128 : dv);
	endfunction
	function automatic int conv_per(input bit osc, input int code);
		return (osc ? 12 : 10) << code;
	endfunction
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rchk(8'h46, 8'h00);
		rchk(8'h47, 8'h01);
		rchk(8'h49, 8'h00);
		w(8'h50, 8'h5a);
		rchk(8'h50, 8'h00);
		w(8'h5b, 8'hf0);
		rchk(8'h5b, 8'h00);
		@(posedge core_clk) ovl1 <= 1'b1;
		@(posedge core_clk) ovl1 <= 1'b0;
		rchk(8'h5b, 8'h80);
		rchk(8'h5b, 8'h00);
		@(posedge core_clk) {ovl1, ovl2} <= 2'b11;
		rchk(8'h5b, 8'hf0);
		rchk(8'h5b, 8'hf0);
		@(posedge core_clk) {ovl1, ovl2} <= 2'b00;
		rchk(8'h5b, 8'hc0);
		rchk(8'h5b, 8'h00);
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			// the fast mode only with the oscillator feeding the divider directly
			if (v[7:6] == 2'h3) begin
				v[5:4] = 2'h3;
				v[1:0] = 2'h0;
			end
			w(8'h49, v[7:0]);
			w(8'h47, v[15:8]);
			rchk(8'h49, v[7:0]);
			rchk(8'h47, v[15:8]);
		end
		for (int s = 0; s < 6; s++) begin
			v = 1 + {$random(seed)} % 4;
			w(8'h46, s[7:0]);
			w(8'h47, 8'h80 | v[7:0]);
			per_chk(1'b0, gp_per(s, v));
		end
		w(8'h47, 8'h80);
		per_chk(1'b0, gp_per(5, 0));
		w(8'h47, 8'h03);
		stop_chk(1'b0);
		for (int r = 0; r < 8; r++) begin
			@(posedge core_clk) conv_auto_request <= r[0];
			w(8'h49, 8'h2c | {3'h0, r[2], 2'h0, r[1:0]});
			per_chk(1'b1, conv_per(r[2], r[1:0]));
		end
		@(posedge core_clk) conv_auto_request <= 1'b1;
		w(8'h49, 8'h2b);
		stop_chk(1'b1);
		for (int m = 0; m < 4; m++) begin
			v = $random(seed);
			@(posedge core_clk) audio_clk_present <= (m != 3);
			w(8'h49, {m[1:0], 1'b0, v[4], 1'b0, v[2:0]});
			v = (m == 3) ? conv_per(1'b1, 0) : conv_per(1'b0, m + 1);
			per_chk(1'b1, v);
		end
		@(posedge core_clk) conv_auto_request <= 1'b0;
		stop_chk(1'b1);
		end_sim;
	end
	initial begin
		#(40 * 80000);
		fail_count++;
		end_sim;
	end
endmodule
